// *** core/rcs_pkg.sv ***
/*
 * Package for the reset and clock start-up sequencer: oscillator modes,
 * reset causes, sequencer states, timing counts and carrier structs.
 * Assumes a single 100 MHz system clock.
 */
package rcs_pkg;

    // ------------------------------------------------------------------
    // Oscillator mode encodings
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        RCS_OSC_LOW_POWER = 2'h0,
        RCS_OSC_STANDARD = 2'h1,
        RCS_OSC_HIGH_SPEED = 2'h2,
        RCS_OSC_RES_CAP = 2'h3
    } rcs_osc_mode_t;

    // ------------------------------------------------------------------
    // Reset causes
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        RCS_CAUSE_NONE = 3'h0,
        RCS_CAUSE_POWER_ON = 3'h1,
        RCS_CAUSE_MASTER_CLEAR_N_RUN = 3'h2,
        RCS_CAUSE_MASTER_CLEAR_N_SLEEP = 3'h3,
        RCS_CAUSE_WATCHDOG = 3'h4,
        RCS_CAUSE_BROWNOUT = 3'h5,
        RCS_CAUSE_WDT_WAKE = 3'h6
    } rcs_cause_t;

    // ------------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        RCS_ST_HOLD = 5'h01,
        RCS_ST_PWRUP = 5'h02,
        RCS_ST_OSTART = 5'h04,
        RCS_ST_WAIT_MASTER_CLEAR_N = 5'h08,
        RCS_ST_RUN = 5'h10
    } rcs_state_t;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int RCS_CLK_HZ = 100_000_000;
    localparam int RCS_PWRUP_MS = 72;
    localparam longint RCS_PWRUP_CYC_L =
        (longint'(RCS_PWRUP_MS) * longint'(RCS_CLK_HZ)) / 1000;
    localparam int RCS_PWRUP_CYC = int'(RCS_PWRUP_CYC_L);
    localparam int RCS_OST_CYCLES = 1024;
    localparam int RCS_FILT_CYCLES = 4;
    localparam int RCS_OSC_DIV = 4;

    // Status flag reset values after power-on
    localparam logic RCS_TIMEOUT_POR = 1'b1;
    localparam logic RCS_POWERDOWN_POR = 1'b1;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic timeout_flag;
        logic powerdown_flag;
    } rcs_flags_t;

    typedef struct packed {
        logic osc_select_hi;
        logic osc_select_lo;
        logic power_up_timer_enable_n;
    } rcs_config_t;

endpackage : rcs_pkg

// *** core/rcs_master_clear_n_filter.sv ***
/*
 * Noise filter for the active-low master clear input. A level change
 * is accepted only after it holds for a set number of clock cycles.
 * Assumes the pin is already synchronous to the clock.
 */
`timescale 1ns/100ps
module rcs_master_clear_n_filter
    import rcs_pkg::*;
#(
    parameter int FILT_CYCLES = RCS_FILT_CYCLES
) (
    input wire logic clk_i, // System clock
    input wire logic nrst_i, // Synchronous reset, active low
    input wire logic pin_n_i, // Raw master clear, active low
    output logic clean_n_o // Filtered master clear, active low
);

    localparam int CW = $clog2(FILT_CYCLES + 1);

    if (FILT_CYCLES < 1) begin : g_bad_filt
        $error("FILT_CYCLES must be at least 1");
    end

    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;
    logic clean_n;
    logic next_clean_n;

    // ------------------------------------------------------------------
    // Filter
    // ------------------------------------------------------------------
    always_comb begin
        next_cnt = '0;
        next_clean_n = clean_n;
        if (pin_n_i != clean_n) begin
            if (cnt == CW'(FILT_CYCLES - 1)) begin
                next_clean_n = pin_n_i;
            end else begin
                next_cnt = cnt + CW'(1);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            cnt <= '0;
            clean_n <= 1'b1;
        end else begin
            cnt <= next_cnt;
            clean_n <= next_clean_n;
        end
    end

    assign clean_n_o = clean_n;

endmodule : rcs_master_clear_n_filter

// *** core/rcs_sequencer.sv ***
/*
 * Reset and clock start-up sequencer: decodes the oscillator mode,
 * divides the oscillator by four in RC mode, sorts reset causes,
 * sets the status flags and times power-up and oscillator start-up.
 * Assumes all inputs are synchronous to CLK_I; the oscillator input
 * and the internal RC oscillator arrive as sampled levels, and the
 * power-on detect pulse comes from an analogue comparator outside.
 */
//
// Behaviour
// - Four oscillator modes chosen by two configuration bits.
// - Select 11 RC, 10 high-speed, 01 standard, 00 low-power.
// - Crystal modes accept an external clock on the input pin.
// - RC mode drives output pin at oscillator frequency divided by four.
// - Distinguish power-on, clear running, clear sleeping, watchdog, brown-out.
// - Some registers are never reset; they keep values except at power-on.
// - Most registers load reset values on power-on, clear and watchdog.
// - Watchdog wake-up is not a reset; registers keep their values.
// - Timeout and powerdown flags record the kind of reset.
// - POR sets both; WDT clears timeout; wake clears both; clr-sleep pd.
// - Master clear has a filter that ignores short pulses.
// - Watchdog reset never drives the master clear pin low.
// - Supply rise produces an internal power-on reset pulse.
// - 72 ms power-up delay runs only after power-on and brown-out reset.
// - Power-up timer counts cycles of its own RC oscillator.
// - Chip stays in reset while the power-up timer counts.
// - Power-up timer can be bypassed by a configuration bit.
// - Enable bit is active low: 0 enables, 1 disables.
// - Start-up timer holds reset 1024 input-clock cycles after power-up.
// - Start-up timer only in crystal modes, after power-on or wake.
`timescale 1ns/100ps
module rcs_sequencer
    import rcs_pkg::*;
#(
    parameter int PWRUP_CYCLES = RCS_PWRUP_CYC,
    parameter int OST_CYCLES = RCS_OST_CYCLES,
    parameter int FILT_CYCLES = RCS_FILT_CYCLES
) (
    input wire logic CLK_I, // System clock, 100 MHz
    input wire logic NRST_I, // Synchronous reset, active low
    input wire logic POWER_ON_PULSE_I, // Supply-rise detect pulse
    input wire logic MASTER_CLEAR_N_I, // Master clear pin, active low
    input wire logic WATCHDOG_TIMEOUT_I, // Watchdog expiry pulse
    input wire logic BROWNOUT_I, // Brown-out detect level
    input wire logic SLEEPING_I, // Core is in sleep
    input wire logic OSC_SELECT_HI_I, // Oscillator select, high bit
    input wire logic OSC_SELECT_LO_I, // Oscillator select, low bit
    input wire logic PWRUP_TIMER_EN_N_I, // Power-up timer enable, low
    input wire logic OSC_INPUT_PIN_I, // Oscillator input level
    input wire logic RC_TICK_I, // Internal RC oscillator level
    output logic OSC_OUTPUT_PIN_O, // Divided clock in RC mode
    output logic OSC_OUTPUT_OE_O, // Output enable, RC mode
    output logic CHIP_RESET_O, // Whole-chip reset, high
    output logic REG_RESET_O, // Reset-state load strobe
    output logic POR_CLEAR_O, // Power-on clear of unreset regs
    output logic TIMEOUT_FLAG_O, // Status: timeout flag
    output logic POWERDOWN_FLAG_O, // Status: powerdown flag
    output logic WAKE_O, // Watchdog wake-up resume pulse
    output logic [2:0] RESET_CAUSE_O, // Last reset cause code
    output logic [1:0] OSC_MODE_O // Decoded oscillator mode
);

    localparam int PW = $clog2(PWRUP_CYCLES + 1);
    localparam int OW = $clog2(OST_CYCLES + 1);

    if (PWRUP_CYCLES < 1 || OST_CYCLES < 1) begin : g_bad_count
        $error("Timer counts must be at least 1");
    end

    // ------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------
    function automatic rcs_osc_mode_t decode_mode(input logic hi,
                                                   input logic lo);
        decode_mode = rcs_osc_mode_t'({hi, lo});
    endfunction : decode_mode

    function automatic logic is_crystal(input rcs_osc_mode_t m);
        is_crystal = (m != RCS_OSC_RES_CAP);
    endfunction : is_crystal

    rcs_config_t cfg;
    rcs_osc_mode_t mode;
    assign cfg = '{OSC_SELECT_HI_I, OSC_SELECT_LO_I, PWRUP_TIMER_EN_N_I};
    assign mode = decode_mode(cfg.osc_select_hi, cfg.osc_select_lo);

    // ------------------------------------------------------------------
    // Master clear filter
    // ------------------------------------------------------------------
    logic master_clear_n_n;

    rcs_master_clear_n_filter #(
        .FILT_CYCLES(FILT_CYCLES)
    ) u_filter (
        .clk_i(CLK_I),
        .nrst_i(NRST_I),
        .pin_n_i(MASTER_CLEAR_N_I),
        .clean_n_o(master_clear_n_n)
    );

    // ------------------------------------------------------------------
    // Edge detection of oscillator, RC and filtered master clear inputs
    // ------------------------------------------------------------------
    logic osc_d;
    logic rc_d;
    logic master_clear_n_d;
    logic osc_rise;
    logic rc_rise;
    logic master_clear_n_fall;
    assign osc_rise = OSC_INPUT_PIN_I & ~osc_d;
    assign rc_rise = RC_TICK_I & ~rc_d;
    assign master_clear_n_fall = ~master_clear_n_n & master_clear_n_d;

    // ------------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------------
    rcs_state_t state;
    rcs_state_t next_state;
    logic [PW-1:0] pw_cnt;
    logic [PW-1:0] next_pw_cnt;
    logic [OW-1:0] ost_cnt;
    logic [OW-1:0] next_ost_cnt;
    logic [1:0] div;
    logic [1:0] next_div;
    rcs_flags_t flags;
    rcs_flags_t next_flags;
    rcs_cause_t cause;
    rcs_cause_t next_cause;
    logic reg_rst;
    logic next_reg_rst;
    logic por_clr;
    logic next_por_clr;
    logic wake;
    logic next_wake;
    logic osc_out;
    logic next_osc_out;

    always_comb begin
        next_state = state;
        next_pw_cnt = pw_cnt;
        next_ost_cnt = ost_cnt;
        next_flags = flags;
        next_cause = cause;
        next_reg_rst = 1'b0;
        next_por_clr = 1'b0;
        next_wake = 1'b0;
        next_div = div;
        next_osc_out = 1'b0;

        // Divide oscillator by four in RC mode
        if (mode == RCS_OSC_RES_CAP) begin
            if (osc_rise) begin
                next_div = div + 2'h1;
            end
            next_osc_out = div[1];
        end else begin
            next_div = 2'h0;
        end

        if (POWER_ON_PULSE_I) begin
            next_state = RCS_ST_HOLD;
            next_cause = RCS_CAUSE_POWER_ON;
            next_flags = '{RCS_TIMEOUT_POR, RCS_POWERDOWN_POR};
            next_por_clr = 1'b1;
            next_reg_rst = 1'b1;
            next_pw_cnt = '0;
            next_ost_cnt = '0;
            if (!cfg.power_up_timer_enable_n) begin
                next_state = RCS_ST_PWRUP;
            end else if (is_crystal(mode)) begin
                next_state = RCS_ST_OSTART;
            end else begin
                next_state = RCS_ST_WAIT_MASTER_CLEAR_N;
            end
        end else if (BROWNOUT_I) begin
            next_state = RCS_ST_HOLD;
            next_cause = RCS_CAUSE_BROWNOUT;
            next_flags = '{1'b1, 1'b1};
            next_reg_rst = 1'b1;
        end else if (WATCHDOG_TIMEOUT_I && state == RCS_ST_RUN) begin
            if (SLEEPING_I) begin
                next_cause = RCS_CAUSE_WDT_WAKE;
                next_flags = '{1'b0, 1'b0};
                next_wake = 1'b1;
                next_ost_cnt = '0;
                if (is_crystal(mode)) begin
                    next_state = RCS_ST_OSTART;
                end
            end else begin
                // Internal only; the pin is an input here
                next_cause = RCS_CAUSE_WATCHDOG;
                next_flags.timeout_flag = 1'b0;
                next_reg_rst = 1'b1;
                next_state = RCS_ST_WAIT_MASTER_CLEAR_N;
            end
        end else if (master_clear_n_fall && state == RCS_ST_RUN) begin
            next_reg_rst = 1'b1;
            next_state = RCS_ST_WAIT_MASTER_CLEAR_N;
            if (SLEEPING_I) begin
                next_cause = RCS_CAUSE_MASTER_CLEAR_N_SLEEP;
                next_flags = '{1'b1, 1'b0};
            end else begin
                next_cause = RCS_CAUSE_MASTER_CLEAR_N_RUN;
            end
        end else begin
            unique case (state)
                RCS_ST_HOLD: begin
                    if (!BROWNOUT_I) begin
                        next_pw_cnt = '0;
                        next_state = cfg.power_up_timer_enable_n ?
                            RCS_ST_WAIT_MASTER_CLEAR_N : RCS_ST_PWRUP;
                    end
                end
                RCS_ST_PWRUP: begin
                    if (rc_rise) begin
                        next_pw_cnt = pw_cnt + PW'(1);
                    end
                    if (pw_cnt == PW'(PWRUP_CYCLES)) begin
                        next_ost_cnt = '0;
                        next_state = (is_crystal(mode) &&
                            cause == RCS_CAUSE_POWER_ON) ?
                            RCS_ST_OSTART : RCS_ST_WAIT_MASTER_CLEAR_N;
                    end
                end
                RCS_ST_OSTART: begin
                    if (osc_rise) begin
                        next_ost_cnt = ost_cnt + OW'(1);
                    end
                    if (ost_cnt == OW'(OST_CYCLES)) begin
                        next_state = RCS_ST_WAIT_MASTER_CLEAR_N;
                    end
                end
                RCS_ST_WAIT_MASTER_CLEAR_N: begin
                    if (master_clear_n_n) begin
                        next_state = RCS_ST_RUN;
                    end
                end
                RCS_ST_RUN: begin
                    next_state = RCS_ST_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            state <= RCS_ST_HOLD;
            pw_cnt <= '0;
            ost_cnt <= '0;
            div <= 2'h0;
            flags <= '{RCS_TIMEOUT_POR, RCS_POWERDOWN_POR};
            cause <= RCS_CAUSE_NONE;
            reg_rst <= 1'b0;
            por_clr <= 1'b0;
            wake <= 1'b0;
            osc_out <= 1'b0;
            osc_d <= 1'b0;
            rc_d <= 1'b0;
            master_clear_n_d <= 1'b1;
        end else begin
            state <= next_state;
            pw_cnt <= next_pw_cnt;
            ost_cnt <= next_ost_cnt;
            div <= next_div;
            flags <= next_flags;
            cause <= next_cause;
            reg_rst <= next_reg_rst;
            por_clr <= next_por_clr;
            wake <= next_wake;
            osc_out <= next_osc_out;
            osc_d <= OSC_INPUT_PIN_I;
            rc_d <= RC_TICK_I;
            master_clear_n_d <= master_clear_n_n;
        end
    end

    // ------------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------------
    logic chip_rst;
    logic oe;
    logic [1:0] mode_q;

    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            chip_rst <= 1'b1;
            oe <= 1'b0;
            mode_q <= 2'h0;
        end else begin
            chip_rst <= (next_state != RCS_ST_RUN);
            oe <= (mode == RCS_OSC_RES_CAP);
            mode_q <= mode;
        end
    end

    assign CHIP_RESET_O = chip_rst;
    assign OSC_OUTPUT_OE_O = oe;
    assign OSC_OUTPUT_PIN_O = osc_out;
    assign OSC_MODE_O = mode_q;
    assign REG_RESET_O = reg_rst;
    assign POR_CLEAR_O = por_clr;
    assign WAKE_O = wake;
    assign TIMEOUT_FLAG_O = flags.timeout_flag;
    assign POWERDOWN_FLAG_O = flags.powerdown_flag;
    assign RESET_CAUSE_O = cause;

endmodule : rcs_sequencer

// *** dv/rcs_sequencer_chk.sv ***
/*
 * Port checker for the reset and clock start-up sequencer.
 * Assumes it is bound to rcs_sequencer and every input is synchronous
 * to CLK_I.
 */
`timescale 1ns/100ps
module rcs_sequencer_chk
    import rcs_pkg::*;
(
    input wire logic CLK_I, // Clock
    input wire logic NRST_I, // Reset, low
    input wire logic POWER_ON_PULSE_I, // Supply rise
    input wire logic MASTER_CLEAR_N_I, // Clear pin
    input wire logic WATCHDOG_TIMEOUT_I, // Watchdog
    input wire logic BROWNOUT_I, // Brown-out
    input wire logic SLEEPING_I, // Sleep
    input wire logic OSC_SELECT_HI_I, // Select hi
    input wire logic OSC_SELECT_LO_I, // Select lo
    input wire logic OSC_OUTPUT_PIN_O, // Divided clock
    input wire logic OSC_OUTPUT_OE_O, // Output enable
    input wire logic CHIP_RESET_O, // Chip reset
    input wire logic REG_RESET_O, // Load strobe
    input wire logic POR_CLEAR_O, // Power-on clear
    input wire logic TIMEOUT_FLAG_O, // Timeout flag
    input wire logic POWERDOWN_FLAG_O, // Powerdown flag
    input wire logic WAKE_O, // Wake pulse
    input wire logic [2:0] RESET_CAUSE_O, // Cause code
    input wire logic [1:0] OSC_MODE_O // Mode
);
    logic [1:0] cfg;
    logic wdt_run;
    assign cfg = {OSC_SELECT_HI_I, OSC_SELECT_LO_I};
    assign wdt_run = WATCHDOG_TIMEOUT_I && !CHIP_RESET_O
        && !POWER_ON_PULSE_I && !BROWNOUT_I;
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!NRST_I);
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    property p_mode;
        ($past(NRST_I) && $past(NRST_I, 2) && cfg == $past(cfg)
            && cfg == $past(cfg, 2)) |->
            (OSC_MODE_O == cfg && OSC_OUTPUT_OE_O == (cfg == 2'h3));
    endproperty
    a_mode: assert property (p_mode)
        else $error("decoded mode or enable wrong");
    property p_pin_idle;
        !OSC_OUTPUT_OE_O |-> !OSC_OUTPUT_PIN_O;
    endproperty
    a_pin_idle: assert property (p_pin_idle)
        else $error("clock output active outside RC mode");
    property p_por;
        POWER_ON_PULSE_I |=> (REG_RESET_O && POR_CLEAR_O && CHIP_RESET_O
            && TIMEOUT_FLAG_O && POWERDOWN_FLAG_O && RESET_CAUSE_O == 3'h1);
    endproperty
    a_por: assert property (p_por)
        else $error("power-on response wrong");
    property p_por_only;
        POR_CLEAR_O |-> RESET_CAUSE_O == 3'h1;
    endproperty
    a_por_only: assert property (p_por_only)
        else $error("unreset registers cleared off power-on");
    property p_wdt_reset;
        (wdt_run && !SLEEPING_I) |=> (REG_RESET_O && CHIP_RESET_O
            && !TIMEOUT_FLAG_O && RESET_CAUSE_O == 3'h4
            && POWERDOWN_FLAG_O == $past(POWERDOWN_FLAG_O));
    endproperty
    a_wdt_reset: assert property (p_wdt_reset)
        else $error("watchdog reset response wrong");
    property p_wdt_wake;
        (wdt_run && SLEEPING_I) |=> (WAKE_O && !REG_RESET_O
            && !TIMEOUT_FLAG_O && !POWERDOWN_FLAG_O && RESET_CAUSE_O == 3'h6);
    endproperty
    a_wdt_wake: assert property (p_wdt_wake)
        else $error("watchdog wake response wrong");
    property p_master_clear_n_filt;
        (REG_RESET_O && RESET_CAUSE_O inside {3'h2, 3'h3}) |->
            (!$past(MASTER_CLEAR_N_I, 3) && !$past(MASTER_CLEAR_N_I, 4)
            && !$past(MASTER_CLEAR_N_I, 5));
    endproperty
    a_master_clear_n_filt: assert property (p_master_clear_n_filt)
        else $error("short clear pulse accepted");
    property p_master_clear_n_run;
        (REG_RESET_O && RESET_CAUSE_O == 3'h2) |->
            (TIMEOUT_FLAG_O == $past(TIMEOUT_FLAG_O)
            && POWERDOWN_FLAG_O == $past(POWERDOWN_FLAG_O));
    endproperty
    a_master_clear_n_run: assert property (p_master_clear_n_run)
        else $error("flags changed by clear while running");
    property p_master_clear_n_sleep;
        (REG_RESET_O && RESET_CAUSE_O == 3'h3) |->
            (TIMEOUT_FLAG_O && !POWERDOWN_FLAG_O);
    endproperty
    a_master_clear_n_sleep: assert property (p_master_clear_n_sleep)
        else $error("flags wrong after clear in sleep");
    property p_release;
        $fell(CHIP_RESET_O) |->
            ($past(MASTER_CLEAR_N_I, 2) && $past(MASTER_CLEAR_N_I, 3));
    endproperty
    a_release: assert property (p_release)
        else $error("reset released with clear pin low");
    property p_bor;
        (BROWNOUT_I && !POWER_ON_PULSE_I) |=> CHIP_RESET_O;
    endproperty
    a_bor: assert property (p_bor)
        else $error("brown-out did not hold reset");
endmodule : rcs_sequencer_chk

// *** dv/rcs_clk_board_model.sv ***
/*
 * Far-side model: external clock source, internal RC tick and the
 * board reset circuit with a pull-up on the clear pin.
 * Assumes the bench clock samples every level it makes.
 */
`timescale 1ns/100ps
module rcs_clk_board_model #(
    parameter int OSC_HALF = 2,
    parameter int RC_HALF = 1
) (
    input wire logic clk_i, // Bench clock
    input wire logic press_i, // Board holds clear low
    output logic osc_o, // External clock level
    output logic rc_o, // RC tick level
    output logic master_clear_n_n_o // Clear pin level
);
    int osc_cnt = 0;
    int rc_cnt = 0;
    // Pin pulled to supply unless the board circuit holds it low
    assign master_clear_n_n_o = !press_i;
    // Free-running external clock in place of a crystal
    assign osc_o = (osc_cnt >= OSC_HALF);
    assign rc_o = (rc_cnt >= RC_HALF);
    always @(posedge clk_i) begin
        osc_cnt <= (osc_cnt == 2 * OSC_HALF - 1) ? 0 : osc_cnt + 1;
        rc_cnt <= (rc_cnt == 2 * RC_HALF - 1) ? 0 : rc_cnt + 1;
    end
endmodule : rcs_clk_board_model

// *** dv/tb_rcs_sequencer.sv ***
/*
 * Self-checking bench for the reset and clock start-up sequencer.
 * Assumes shortened power-up and start-up counts and a far-side model.
 */
`timescale 1ns/100ps
module tb_rcs_sequencer
    import rcs_pkg::*;
;
    localparam int PWRUP = 20;
    localparam int OSC_STARTUP_TIMER = 8;
    localparam int RC_PER = 2;
    localparam int OSC_PER = 4;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic por = 1'b0;
    logic press = 1'b0;
    logic wdt = 1'b0;
    logic bor = 1'b0;
    logic sleep = 1'b0;
    logic sel_hi = 1'b0;
    logic sel_lo = 1'b0;
    logic pte_n = 1'b0;
    logic osc, rc, master_clear_n_n, osc_out, osc_oe, chip_rst, reg_rst, por_clr;
    logic tmo, pdn, wake;
    logic [2:0] cause;
    logic [1:0] mode;
    int n_errors = 0;
    int tests_run = 0;
    always #5 clk = ~clk;
    rcs_sequencer #(.PWRUP_CYCLES(PWRUP), .OST_CYCLES(OSC_STARTUP_TIMER),
        .FILT_CYCLES(4)) u_rcs_sequencer (.CLK_I(clk), .NRST_I(nrst),
        .POWER_ON_PULSE_I(por), .MASTER_CLEAR_N_I(master_clear_n_n),
        .WATCHDOG_TIMEOUT_I(wdt), .BROWNOUT_I(bor), .SLEEPING_I(sleep),
        .OSC_SELECT_HI_I(sel_hi), .OSC_SELECT_LO_I(sel_lo),
        .PWRUP_TIMER_EN_N_I(pte_n), .OSC_INPUT_PIN_I(osc), .RC_TICK_I(rc),
        .OSC_OUTPUT_PIN_O(osc_out), .OSC_OUTPUT_OE_O(osc_oe),
        .CHIP_RESET_O(chip_rst), .REG_RESET_O(reg_rst),
        .POR_CLEAR_O(por_clr), .TIMEOUT_FLAG_O(tmo),
        .POWERDOWN_FLAG_O(pdn), .WAKE_O(wake), .RESET_CAUSE_O(cause),
        .OSC_MODE_O(mode));
    rcs_clk_board_model #(.OSC_HALF(OSC_PER / 2), .RC_HALF(RC_PER / 2))
        u_rcs_clk_board_model (.clk_i(clk), .press_i(press), .osc_o(osc),
        .rc_o(rc), .master_clear_n_n_o(master_clear_n_n));
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_range(input int got, input int lo, input int hi);
        tests_run++;
        if (got < lo || got > hi) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, lo);
        end
    endtask : chk_range
    function automatic logic [7:0] st();
        return {2'h0, tmo, pdn, wake, cause};
    endfunction : st
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    // One-cycle pulse: watchdog expiry when w is set, else power-on
    task automatic pulse(input logic w);
        @(posedge clk);
        if (w) begin
            wdt <= 1'b1;
        end else begin
            por <= 1'b1;
        end
        @(posedge clk);
        wdt <= 1'b0;
        por <= 1'b0;
        #1;
    endtask : pulse
    task automatic wait_run(output int c);
        c = 0;
        while (chip_rst !== 1'b0) begin
            cyc(1);
            c++;
            if (c > 2000) begin
                chk(8'(chip_rst), 8'h0);
                conclude();
            end
        end
    endtask : wait_run
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_timeout(input logic [1:0] m, input logic p);
        int exp_c;
        int c;
        @(posedge clk);
        {sel_hi, sel_lo} <= m;
        pte_n <= p;
        cyc(3);
        chk({5'h0, osc_oe, mode}, {5'h0, m == 2'h3, m});
        pulse(1'b0);
        chk(st(), 8'h31);
        exp_c = (p ? 0 : PWRUP * RC_PER) + (m == 2'h3 ? 0 : OSC_STARTUP_TIMER * OSC_PER);
        wait_run(c);
        chk_range(c + 4, exp_c, exp_c + 16);
        $display("test timeout mode %0d enable_n %0d done", m, p);
    endtask : t_timeout
    task automatic t_div();
        int n;
        logic prev;
        n = 0;
        prev = osc_out;
        repeat (160) begin
            cyc(1);
            n += (osc_out && !prev) ? 1 : 0;
            prev = osc_out;
        end
        chk_range(n, 9, 11);
        $display("test divide done");
    endtask : t_div
    task automatic t_wdt();
        int c;
        pulse(1'b1);
        chk(st(), 8'h14);
        wait_run(c);
        chk_range(c, 0, 6);
        @(posedge clk);
        sleep <= 1'b1;
        pulse(1'b1);
        chk(st(), 8'h0E);
        @(posedge clk);
        sleep <= 1'b0;
        wait_run(c);
        chk_range(c + 4, OSC_STARTUP_TIMER * OSC_PER, OSC_STARTUP_TIMER * OSC_PER + 16);
        $display("test watchdog done");
    endtask : t_wdt
    task automatic t_master_clear_n();
        int c;
        @(posedge clk);
        press <= 1'b1;
        repeat (2) @(posedge clk);
        press <= 1'b0;
        cyc(10);
        chk({chip_rst, 7'(st())}, 8'h06);
        @(posedge clk);
        sleep <= 1'b1;
        press <= 1'b1;
        cyc(10);
        chk({chip_rst, 7'(st())}, 8'hA3);
        @(posedge clk);
        sleep <= 1'b0;
        press <= 1'b0;
        wait_run(c);
        @(posedge clk);
        press <= 1'b1;
        cyc(10);
        chk(st(), 8'h22);
        @(posedge clk);
        press <= 1'b0;
        wait_run(c);
        $display("test master clear done");
    endtask : t_master_clear_n
    task automatic t_bor();
        int c;
        @(posedge clk);
        bor <= 1'b1;
        cyc(5);
        chk({chip_rst, 7'(st())}, 8'hB5);
        @(posedge clk);
        bor <= 1'b0;
        wait_run(c);
        $display("test brown-out done");
    endtask : t_bor
    initial begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        t_timeout(2'h0, 1'b0);
        t_timeout(2'h2, 1'b0);
        t_timeout(2'h3, 1'b0);
        t_timeout(2'h3, 1'b1);
        t_div();
        t_timeout(2'h1, 1'b1);
        t_wdt();
        t_master_clear_n();
        t_bor();
        conclude();
    end
endmodule : tb_rcs_sequencer
bind rcs_sequencer rcs_sequencer_chk u_rcs_sequencer_chk (.CLK_I(CLK_I),
    .NRST_I(NRST_I), .POWER_ON_PULSE_I(POWER_ON_PULSE_I),
    .MASTER_CLEAR_N_I(MASTER_CLEAR_N_I),
    .WATCHDOG_TIMEOUT_I(WATCHDOG_TIMEOUT_I), .BROWNOUT_I(BROWNOUT_I),
    .SLEEPING_I(SLEEPING_I), .OSC_SELECT_HI_I(OSC_SELECT_HI_I),
    .OSC_SELECT_LO_I(OSC_SELECT_LO_I), .OSC_OUTPUT_PIN_O(OSC_OUTPUT_PIN_O),
    .OSC_OUTPUT_OE_O(OSC_OUTPUT_OE_O), .CHIP_RESET_O(CHIP_RESET_O),
    .REG_RESET_O(REG_RESET_O), .POR_CLEAR_O(POR_CLEAR_O),
    .TIMEOUT_FLAG_O(TIMEOUT_FLAG_O), .POWERDOWN_FLAG_O(POWERDOWN_FLAG_O),
    .WAKE_O(WAKE_O), .RESET_CAUSE_O(RESET_CAUSE_O), .OSC_MODE_O(OSC_MODE_O));
